// ---- hw/lcdb_defs.svh ----
// Constants of the LCD bias and power control block.
// Assumes 8-bit special function register addresses and data.
`ifndef LCDB_DEFS_SVH
`define LCDB_DEFS_SVH

`define LCDB_ADDR_MAIN_CONFIG    8'h95
`define LCDB_ADDR_SEG_ENABLE_A   8'h97
`define LCDB_ADDR_SUPPLY_BIAS    8'h9c
`define LCDB_ADDR_SEG_POINTER    8'hac
`define LCDB_ADDR_SEG_DATA       8'hae
`define LCDB_ADDR_UPDATE_CTRL    8'hb1
`define LCDB_ADDR_SEG_ENABLE_B   8'hed
`define LCDB_ADDR_PERIPHERAL_CONFIG_CONFIG  8'hf4

`define LCDB_BIT_DISPLAY_ON      7
`define LCDB_BIT_BIAS_HALF       6
`define LCDB_BIT_SLEEP_GATE      4
`define LCDB_MUX_LSB             0
`define LCDB_MUX_MSB             1
`define LCDB_MUX_FOUR            2'h3
`define LCDB_BIT_LADDER_SELECT   6
`define LCDB_LEVEL_LSB           0
`define LCDB_LEVEL_MSB           5
`define LCDB_BIT_REF_KEEPALIVE   3
`define LCDB_BIT_FREEZE          0
`define LCDB_BIT_PTR_WRITE       7
`define LCDB_PTR_ADDR_LSB        0
`define LCDB_PTR_ADDR_MSB        3
`define LCDB_PTR_SCREEN_LSB      4
`define LCDB_PTR_SCREEN_MSB      5

`define LCDB_SEG_PINS            29
`define LCDB_FIXED_SEG_PINS      16
`define LCDB_PIN_SHARED_THREE    27
`define LCDB_PIN_SHARED_TWO      28
`define LCDB_BYTES_PER_SCREEN    15
`define LCDB_SCREENS             4
`define LCDB_RESET_BYTE          8'h00
`define LCDB_ENABLE_BITS         8
`define LCDB_ONE_THIRD           2'h1
`define LCDB_TWO_THIRDS          2'h2
`define LCDB_THIRDS              9'h003

`endif

// ---- hw/lcdb_pkg.sv ----
// Types of the LCD bias and power control block.
// Assumes lcdb_defs.svh is on the include path.
`include "lcdb_defs.svh"
package lcdb_pkg;

    typedef struct packed {
        logic [7:0] mainConfig;
        logic [7:0] segEnableA;
        logic [7:0] supplyBias;
        logic [7:0] segEnableB;
        logic [7:0] periphConfig;
        logic [7:0] updateControl;
        logic [7:0] segPointer;
        logic [7:0] segData;
    } lcdb_regs_t;

    typedef struct packed {
        logic [6:0] railA;
        logic [6:0] railB;
        logic [6:0] railC;
    } lcdb_rails_t;

    typedef struct packed {
        lcdb_regs_t                    regs;
        logic [7:0]                    rdData;
        logic                          displayActive;
        logic                          pumpEnable;
        logic                          ladderSelect;
        logic                          compensationEnable;
        logic                          displayFreeze;
        logic                          sharedCommonTwo;
        logic                          sharedCommonThree;
        logic [`LCDB_SEG_PINS-1:0]     segPinEnable;
        lcdb_rails_t                   rails;
    } lcdb_state_t;

endpackage

// ---- hw/lcdb_seg_mem.sv ----
// Segment data memory: four screens of fifteen bytes in flip-flops.
// Assumes one write or one read request per cycle from the owner.
`timescale 1ns/1ps
`include "lcdb_defs.svh"
module lcdb_seg_mem #(
    parameter int SCREENS = `LCDB_SCREENS,
    parameter int BYTES   = `LCDB_BYTES_PER_SCREEN
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       writeEn,
    input  wire logic [1:0] screen,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] writeData,
    output logic      [7:0] readData
);

    logic [SCREENS*BYTES-1:0][7:0] mem_reg;
    logic [SCREENS*BYTES-1:0][7:0] mem_next;
    logic                          inRange;
    logic [7:0]                    index;

    always_comb
    begin
        inRange  = 32'(addr) < BYTES;
        index    = 8'(32'(screen) * BYTES + 32'(addr));
        mem_next = mem_reg;
        if (writeEn && inRange)
        begin
            mem_next[index] = writeData;
        end
        readData = inRange ? mem_reg[index] : `LCDB_RESET_BYTE;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mem_reg <= '0;
        end
        else
        begin
            mem_reg <= mem_next;
        end
    end

endmodule

// ---- hw/lcdb_power_ctrl.sv ----
// LCD waveform supply selection, bias rails, power gating and segment
// memory access through special function registers.
// Assumes a one-cycle register port from the controller core and a power
// manager that reports the deepest power-saving mode as a level.
`timescale 1ns/1ps
`include "lcdb_defs.svh"
module lcdb_power_ctrl #(
    parameter logic [6:0] REF_CODE = 7'h10
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic [7:0]                 sfrAddr,
    input  wire logic [7:0]                 sfrWrData,
    input  wire logic                       sfrWrite,
    input  wire logic                       sfrRead,
    input  wire logic                       deepestPowerSave,
    output logic      [7:0]                 sfrRdData,
    output logic                            displayActive,
    output logic                            pumpEnable,
    output logic                            ladderSelect,
    output logic                            compensationEnable,
    output logic                            displayFreeze,
    output logic                            sharedCommonTwo,
    output logic                            sharedCommonThree,
    output logic      [`LCDB_SEG_PINS-1:0]  segPinEnable,
    output lcdb_pkg::lcdb_rails_t           biasRails
);

    lcdb_pkg::lcdb_state_t s_reg;
    lcdb_pkg::lcdb_state_t s_next;
    logic                  memWrite;
    logic [7:0]            memReadData;
    logic                  displayOn;
    logic                  deepGate;
    logic                  refKeep;
    logic                  fourCommons;
    logic                  displayNow;
    logic [5:0]            contrastLevel;
    logic [6:0]            railSum;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    function automatic logic ptr_stores(input logic [7:0] ptrByte);
        ptr_stores = ptrByte[`LCDB_BIT_PTR_WRITE];
    endfunction

    // Scales a rail code by a number of thirds, multiplying first.
    function automatic logic [6:0] thirds(input logic [6:0] code,
                                          input logic [1:0] parts);
        logic [8:0] scaled;
        scaled = 9'(code) * 9'(parts);
        thirds = 7'(scaled / `LCDB_THIRDS);
    endfunction

    // Low pins are always segments; the rest follow the enable registers.
    function automatic logic seg_enabled(input int         pin,
                                         input logic [7:0] enA,
                                         input logic [7:0] enB);
        if (pin < `LCDB_FIXED_SEG_PINS)
        begin
            seg_enabled = 1'b1;
        end
        else if (pin < `LCDB_FIXED_SEG_PINS + `LCDB_ENABLE_BITS)
        begin
            seg_enabled = enB[3'(pin - `LCDB_FIXED_SEG_PINS)];
        end
        else
        begin
            seg_enabled = enA[3'(pin - `LCDB_FIXED_SEG_PINS
                                 - `LCDB_ENABLE_BITS)];
        end
    endfunction

    lcdb_seg_mem u_mem (
        .clock     (clock),
        .rst       (rst),
        .writeEn   (memWrite),
        .screen    (sfrWrData[`LCDB_PTR_SCREEN_MSB:`LCDB_PTR_SCREEN_LSB]),
        .addr      (sfrWrData[`LCDB_PTR_ADDR_MSB:`LCDB_PTR_ADDR_LSB]),
        .writeData (s_reg.regs.segData),
        .readData  (memReadData)
    );

    always_comb
    begin
        s_next   = s_reg;
        memWrite = sfrWrite && hit(sfrAddr, `LCDB_ADDR_SEG_POINTER)
                   && ptr_stores(sfrWrData);
        if (sfrWrite)
        begin
            unique case (sfrAddr)
                `LCDB_ADDR_MAIN_CONFIG:   s_next.regs.mainConfig = sfrWrData;
                `LCDB_ADDR_SEG_ENABLE_A:  s_next.regs.segEnableA = sfrWrData;
                `LCDB_ADDR_SUPPLY_BIAS:   s_next.regs.supplyBias = sfrWrData;
                `LCDB_ADDR_SEG_ENABLE_B:  s_next.regs.segEnableB = sfrWrData;
                `LCDB_ADDR_PERIPHERAL_CONFIG_CONFIG: s_next.regs.periphConfig = sfrWrData;
                `LCDB_ADDR_UPDATE_CTRL:   s_next.regs.updateControl = sfrWrData;
                `LCDB_ADDR_SEG_DATA:      s_next.regs.segData = sfrWrData;
                `LCDB_ADDR_SEG_POINTER:
                begin
                    s_next.regs.segPointer = sfrWrData;
                    if (!ptr_stores(sfrWrData))
                    begin
                        s_next.regs.segData = memReadData;
                    end
                end
                default: ;
            endcase
        end

        s_next.rdData = `LCDB_RESET_BYTE;
        if (sfrRead)
        begin
            unique case (sfrAddr)
                `LCDB_ADDR_MAIN_CONFIG:   s_next.rdData = s_reg.regs.mainConfig;
                `LCDB_ADDR_SEG_ENABLE_A:  s_next.rdData = s_reg.regs.segEnableA;
                `LCDB_ADDR_SUPPLY_BIAS:   s_next.rdData = s_reg.regs.supplyBias;
                `LCDB_ADDR_SEG_ENABLE_B:  s_next.rdData = s_reg.regs.segEnableB;
                `LCDB_ADDR_PERIPHERAL_CONFIG_CONFIG:
                    s_next.rdData = s_reg.regs.periphConfig;
                `LCDB_ADDR_UPDATE_CTRL:
                    s_next.rdData = s_reg.regs.updateControl;
                `LCDB_ADDR_SEG_POINTER:   s_next.rdData = s_reg.regs.segPointer;
                `LCDB_ADDR_SEG_DATA:      s_next.rdData = s_reg.regs.segData;
                default:                  s_next.rdData = `LCDB_RESET_BYTE;
            endcase
        end

        displayOn     = s_reg.regs.mainConfig[`LCDB_BIT_DISPLAY_ON];
        deepGate      = s_reg.regs.mainConfig[`LCDB_BIT_SLEEP_GATE];
        refKeep       = s_reg.regs.periphConfig[`LCDB_BIT_REF_KEEPALIVE];
        fourCommons   = s_reg.regs.mainConfig[`LCDB_MUX_MSB:`LCDB_MUX_LSB]
                        == `LCDB_MUX_FOUR;
        contrastLevel = s_reg.regs.supplyBias[`LCDB_LEVEL_MSB:`LCDB_LEVEL_LSB];

        // Registers and memory never clear on display off.
        if (deepestPowerSave)
        begin
            displayNow = displayOn && !deepGate && refKeep;
        end
        else
        begin
            displayNow = displayOn;
        end
        s_next.displayActive = displayNow;

        s_next.ladderSelect =
            s_reg.regs.supplyBias[`LCDB_BIT_LADDER_SELECT];
        s_next.pumpEnable = !s_next.ladderSelect && displayNow;
        s_next.compensationEnable = s_next.pumpEnable;

        railSum = REF_CODE + 7'(contrastLevel);
        if (!s_next.pumpEnable)
        begin
            s_next.rails = '0;
        end
        else if (s_reg.regs.mainConfig[`LCDB_BIT_BIAS_HALF])
        begin
            s_next.rails.railC = railSum;
            s_next.rails.railB = railSum >> 1;
            s_next.rails.railA = railSum >> 1;
        end
        else
        begin
            s_next.rails.railC = railSum;
            s_next.rails.railB = thirds(railSum, `LCDB_TWO_THIRDS);
            s_next.rails.railA = thirds(railSum, `LCDB_ONE_THIRD);
        end

        s_next.displayFreeze =
            s_reg.regs.updateControl[`LCDB_BIT_FREEZE];

        for (int pin = 0; pin < `LCDB_SEG_PINS; pin++)
        begin
            s_next.segPinEnable[pin] = seg_enabled(pin,
                                                   s_reg.regs.segEnableA,
                                                   s_reg.regs.segEnableB);
        end
        s_next.sharedCommonTwo   = fourCommons;
        s_next.sharedCommonThree = fourCommons;
        if (fourCommons)
        begin
            s_next.segPinEnable[`LCDB_PIN_SHARED_TWO]   = 1'b0;
            s_next.segPinEnable[`LCDB_PIN_SHARED_THREE] = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign sfrRdData          = s_reg.rdData;
    assign displayActive      = s_reg.displayActive;
    assign pumpEnable         = s_reg.pumpEnable;
    assign ladderSelect       = s_reg.ladderSelect;
    assign compensationEnable = s_reg.compensationEnable;
    assign displayFreeze      = s_reg.displayFreeze;
    assign sharedCommonTwo    = s_reg.sharedCommonTwo;
    assign sharedCommonThree  = s_reg.sharedCommonThree;
    assign segPinEnable       = s_reg.segPinEnable;
    assign biasRails          = s_reg.rails;

endmodule

// ---- tb/lcdb_power_ctrl_properties.sv ----
// Port assertions of the LCD bias and power controller.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
`include "lcdb_defs.svh"
module lcdb_power_ctrl_properties #(
    parameter logic [6:0] REF_CODE = 7'h10
) (
    input wire logic                     clock,
    input wire logic                     rst,
    input wire logic [7:0]               sfrAddr,
    input wire logic [7:0]               sfrWrData,
    input wire logic                     sfrWrite,
    input wire logic                     sfrRead,
    input wire logic                     deepestPowerSave,
    input wire logic [7:0]               sfrRdData,
    input wire logic                     displayActive,
    input wire logic                     pumpEnable,
    input wire logic                     ladderSelect,
    input wire logic                     compensationEnable,
    input wire logic                     displayFreeze,
    input wire logic                     sharedCommonTwo,
    input wire logic                     sharedCommonThree,
    input wire logic [`LCDB_SEG_PINS-1:0] segPinEnable,
    input wire lcdb_pkg::lcdb_rails_t    biasRails
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_sel;
        sfrWrite && sfrAddr == 8'h9c ##1 !(sfrWrite && sfrAddr == 8'h9c)
        |-> ##1 ladderSelect == $past(sfrWrData[6], 2);
    endproperty
    a_sel: assert property (p_sel) else $error("ladder select wrong");
    property p_ladder;
        ladderSelect |-> !pumpEnable;
    endproperty
    a_ladder: assert property (p_ladder) else $error("pump on ladder");
    property p_comp;
        compensationEnable == pumpEnable;
    endproperty
    a_comp: assert property (p_comp) else $error("compensation wrong");
    property p_off;
        !displayActive |-> !pumpEnable && biasRails == '0;
    endproperty
    a_off: assert property (p_off) else $error("pump on while off");
    property p_rail;
        pumpEnable |-> biasRails.railC >= REF_CODE
            && biasRails.railC <= REF_CODE + 7'd63
            && biasRails.railA <= biasRails.railB;
    endproperty
    a_rail: assert property (p_rail) else $error("rail range");
    property p_seg;
        !$past(rst) && !$past(rst, 2) |-> segPinEnable[15:0] == 16'hffff;
    endproperty
    a_seg: assert property (p_seg) else $error("fixed segment off");
    property p_shr;
        !(sharedCommonTwo && segPinEnable[28])
            && !(sharedCommonThree && segPinEnable[27]);
    endproperty
    a_shr: assert property (p_shr) else $error("common as segment");
    property p_deep;
        sfrWrite && sfrAddr == 8'h95 && sfrWrData[4] && deepestPowerSave
        ##1 deepestPowerSave && !(sfrWrite && sfrAddr == 8'h95)
        |-> ##1 !displayActive;
    endproperty
    a_deep: assert property (p_deep) else $error("gate lost");
    property p_idle;
        !$past(sfrRead) |-> sfrRdData == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data stands");
endmodule
bind lcdb_power_ctrl lcdb_power_ctrl_properties #(.REF_CODE(REF_CODE))
    u_props (
    .clock(clock), .rst(rst), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdData(sfrRdData),
    .deepestPowerSave(deepestPowerSave), .displayActive(displayActive),
    .pumpEnable(pumpEnable), .ladderSelect(ladderSelect),
    .compensationEnable(compensationEnable), .displayFreeze(displayFreeze),
    .sharedCommonTwo(sharedCommonTwo), .sharedCommonThree(sharedCommonThree),
    .segPinEnable(segPinEnable), .biasRails(biasRails));

// ---- tb/lcdb_glass_model.sv ----
// Passive LCD glass: lights only when a waveform supply is present.
// Assumes the rails are zero whenever the on-chip pump is stopped.
`timescale 1ns/1ps
module lcdb_glass_model (
    input  wire logic                  displayActive,
    input  wire logic                  ladderSelect,
    input  wire lcdb_pkg::lcdb_rails_t biasRails,
    output logic                       lit
);
    assign lit = displayActive
                 && (ladderSelect || biasRails.railC != 7'h00);
endmodule

// ---- tb/lcdb_power_ctrl_tb_top.sv ----
// Self-checking bench of the LCD bias and power controller.
// Assumes the controller, checker and glass model are compiled first.
`timescale 1ns/1ps
`include "lcdb_defs.svh"
module lcdb_power_ctrl_tb_top;
    localparam logic [6:0] REF = 7'h11;
    localparam logic [7:0] ADR [8] = '{8'h95, 8'h97, 8'h9c, 8'hed,
                                       8'hf4, 8'hb1, 8'hac, 8'hae};
    logic clock, rst, sfrWrite, sfrRead, deepestPowerSave, lit, rdSeen, e;
    logic displayActive, pumpEnable, ladderSelect, compensationEnable;
    logic displayFreeze, sharedCommonTwo, sharedCommonThree;
    logic [7:0]                sfrAddr, sfrWrData, sfrRdData, m, s, a, b, p;
    logic [7:0]                c, dv [4];
    logic [`LCDB_SEG_PINS-1:0] segPinEnable, sg;
    logic [31:0]               seed;
    lcdb_pkg::lcdb_rails_t     biasRails, er;
    logic [7:0]                rdQ [$];
    int                        err_total, check_count;
    lcdb_power_ctrl #(.REF_CODE(REF)) lcdb_power_ctrl_i (
        .clock(clock), .rst(rst), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
        .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdData(sfrRdData),
        .deepestPowerSave(deepestPowerSave), .displayActive(displayActive),
        .pumpEnable(pumpEnable), .ladderSelect(ladderSelect),
        .compensationEnable(compensationEnable), .displayFreeze(displayFreeze),
        .sharedCommonTwo(sharedCommonTwo), .sharedCommonThree(sharedCommonThree),
        .segPinEnable(segPinEnable), .biasRails(biasRails));
    lcdb_glass_model lcdb_glass_model_i (.displayActive(displayActive),
        .ladderSelect(ladderSelect), .biasRails(biasRails), .lit(lit));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input string n, input logic [31:0] sn, ex);
        check_count++;
        if (sn !== ex)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, ex, sn);
        end
    endtask
    task automatic wr(input logic [7:0] ad, dt);
        sfrRead = 1'b0;
        sfrAddr = ad;
        sfrWrData = dt;
        sfrWrite = 1'b1;
        @(negedge clock);
    endtask
    task automatic rd(input logic [7:0] ad, ex);
        sfrWrite = 1'b0;
        sfrAddr = ad;
        sfrRead = 1'b1;
        rdQ.push_back(ex);
        @(negedge clock);
    endtask
    task automatic idle(input int n);
        sfrWrite = 1'b0;
        sfrRead = 1'b0;
        repeat (n) @(negedge clock);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clock) rdSeen <= sfrRead;
    always @(negedge clock)
        if (rdSeen === 1'b1)
            check("rd", 32'(sfrRdData), 32'(rdQ.pop_front()));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial
    begin
        #100000;
        err_total++;
        wrap_up();
    end
    initial
    begin
        {rst, seed} = {1'b1, 32'd12};
        {sfrWrite, sfrRead, sfrAddr, sfrWrData, deepestPowerSave} = '0;
        repeat (16) @(negedge clock);
        rst = 1'b0;
        foreach (ADR[i]) rd(ADR[i], 8'h00);
        idle(2);
        check("seg", 32'(segPinEnable), 32'h000ffff);
        check("ladder", 32'(ladderSelect), 32'h0);
        for (int i = 0; i < 48; i++)
        begin
            seed = xs(seed);
            {m, s, a, b} = seed;
            seed = xs(seed);
            {p, deepestPowerSave} = seed[8:0];
            wr(8'h95, m); wr(8'h9c, s); wr(8'h97, a); wr(8'hed, b);
            wr(8'hf4, p); wr(8'h10, m);
            idle(2);
            e = deepestPowerSave ? m[7] & !m[4] & p[3] : m[7];
            c = (e & !s[6]) ? 8'(REF) + 8'(s[5:0]) : 8'h00;
            er.railC = c[6:0];
            er.railB = m[6] ? c[7:1] : 7'((2 * c) / 3);
            er.railA = m[6] ? c[7:1] : 7'(c / 3);
            sg = {a[4:0], b, 16'hffff};
            if (m[1:0] == 2'h3) sg[28:27] = 2'b00;
            check("disp", 32'(displayActive), 32'(e));
            check("pump", 32'(pumpEnable), 32'(e & !s[6]));
            check("ladder", 32'(ladderSelect), 32'(s[6]));
            check("comp", 32'(compensationEnable), 32'(e & !s[6]));
            check("rails", 32'(biasRails), 32'(er));
            check("seg", 32'(segPinEnable), 32'(sg));
            check("com", 32'({sharedCommonTwo, sharedCommonThree}),
                  32'({2{m[1:0] == 2'h3}}));
            check("lit", 32'(lit), 32'(e));
            rd(8'h95, m); rd(8'h9c, s); rd(8'h97, a); rd(8'hed, b);
            rd(8'hf4, p); rd(8'h10, 8'h00);
        end
        {deepestPowerSave, seed} = {1'b0, xs(seed)};
        wr(8'h95, 8'h00); wr(8'hb1, 8'h01);
        idle(2);
        check("freeze", 32'(displayFreeze), 32'h1);
        for (int j = 0; j < 4; j++)
        begin
            dv[j] = seed[8*j+:8];
            wr(8'hae, dv[j]);
            wr(8'hac, 8'h80 | 8'(j << 4) | 8'(j * 4 + 2));
        end
        wr(8'hae, 8'h5a);
        wr(8'hac, 8'h8f);
        wr(8'hb1, 8'h00);
        wr(8'h95, 8'h80);
        idle(2);
        check("freeze", 32'(displayFreeze), 32'h0);
        check("disp", 32'(displayActive), 32'h1);
        wr(8'h95, 8'h00);
        idle(2);
        check("disp", 32'(displayActive), 32'h0);
        for (int j = 0; j < 4; j++)
        begin
            wr(8'hac, 8'(j << 4) | 8'(j * 4 + 2));
            idle(1);
            rd(8'hae, dv[j]);
        end
        wr(8'hac, 8'h0f);
        idle(1);
        rd(8'hae, 8'h00);
        idle(3);
        wrap_up();
    end
endmodule
